// ===== smc_defs.svh
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH

// clock figures; the rate is derived from the period
`define SMC_CLK_PERIOD_NS 32'h0000_0005
`define SMC_CLK_HZ (32'h3B9A_CA00 / `SMC_CLK_PERIOD_NS)

// field widths
`define SMC_SPEED_W 21
`define SMC_OFS_W 24
`define SMC_POS_W 32

// offset and target range, and the one 24-bit pattern outside it
`define SMC_OFS_MAX 24'h7F_FFFF
`define SMC_OFS_BAD 24'h80_0000

// starting speed range in steps per second
`define SMC_SPEED_MIN 21'h00_0001
`define SMC_SPEED_MAX 21'h1E_847F

// reset and homing values
`define SMC_POS_RST 32'h0000_0000
`define SMC_HOME_POS 32'h0000_0000
`define SMC_UNTRUSTED_RST 1'b1

// synchronised pin positions
`define SMC_NPIN 4
`define SMC_PIN_CW 0
`define SMC_PIN_CCW 1
`define SMC_PIN_ESTOP 2
`define SMC_PIN_JSTOP 3

`endif

// ===== smc_pkg.sv
package smc_pkg;
`include "smc_defs.svh"

typedef logic [`SMC_SPEED_W-1:0] smc_speed_t;

typedef enum logic {SMC_KIND_REL, SMC_KIND_ABS} smc_kind_e;

typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_STOP, ST_HOLD, ST_PAUSED} smc_state_e;

// speed in steps/s, rates in steps/s per second
typedef struct packed {
   smc_speed_t speed;
   smc_speed_t accel;
   smc_speed_t decel;
} smc_profile_s;

typedef struct packed {
   logic busy;
   logic paused;
   logic position_not_trusted;
   logic cw_fault;
   logic ccw_fault;
} smc_status_s;

endpackage

// ===== smc_step_rate.sv
`timescale 1ns/1ps
`include "smc_defs.svh"

// phase accumulator: one tick per step at the given speed
module smc_step_rate
   import smc_pkg::*;
#(
   parameter int unsigned CLK_HZ = `SMC_CLK_HZ
)
(
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // rate control
   input wire logic enable,
   input smc_speed_t speed,
   // step tick, combinational
   output logic tick
);

   logic [31:0] acc;
   logic [31:0] sum;

   // tick is combinational so the caller can veto it in the same cycle
   assign sum = acc + {11'h000, speed};
   assign tick = enable && (sum >= CLK_HZ);

   // phase restarts from zero whenever stepping is disabled
   always_ff @(posedge clock)
   begin
      if (reset || !enable)
      begin
         acc <= 32'h0000_0000;
      end
      else if (tick)
      begin
         acc <= sum - CLK_HZ;
      end
      else
      begin
         acc <= sum;
      end
   end

endmodule

// ===== smc_move_ctrl.sv
`timescale 1ns/1ps
`include "smc_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// Function
// R1: controlled stop decelerates to start speed, stops
// R2: controlled stop keeps position trusted
// R3: immediate stop halts steps, marks position untrusted
// R4: untrusted position refuses absolute moves
// R5: halt request rising edge stops, no restart
// R6: jog stop input edge stops jogs only
// R7: limit activation during move stops immediately
// R8: emergency stop input stops immediately, no restart
// R9: relative offset signed, within 8388607 counts
// R10: relative moves allowed while position untrusted
// R11: pause decelerates, stops, then sets paused flag; pausing a jog stops it to ST_IDLE with no paused flag
// R12: paused move continues or is abandoned
// R13: continue takes new profile, keeps target
// R14: absolute move direction and count from position
// R15: absolute moves only with trusted position
// R16: preset or homing marks position trusted
// R17: jog runs while its bit stays set
// R18: jog may start away from active limit
// R19: jog takes new speed and rates live
// R20: jog speed below start speed is ignored
// R21: jog bit cleared gives controlled stop
// R22: travel-direction limit blocks until fault clear
// R23: moves begin at clamped starting speed
// R24: position counts each step by direction
module smc_move_ctrl
   import smc_pkg::*;
#(
   parameter int unsigned CLK_HZ = `SMC_CLK_HZ
)
(
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // host move command
   input wire logic move_start,
   input smc_kind_e move_kind,
   input wire logic signed [`SMC_OFS_W-1:0] move_target,
   input smc_profile_s move_profile,
   input wire logic pause_request,
   input wire logic continue_request,
   input wire logic abrupt_halt_request,
   input wire logic clear_faults_cmd,
   input wire logic jog_cw_cmd,
   input wire logic jog_ccw_cmd,
   input wire logic preset_strobe,
   input wire logic signed [`SMC_POS_W-1:0] preset_value,
   input wire logic home_done,
   // configuration
   input smc_speed_t start_speed,
   // pins, active high
   input wire logic limit_cw_in,
   input wire logic limit_ccw_in,
   input wire logic estop_in,
   input wire logic jog_stop_in,
   // motor
   output logic step_pulse,
   output logic step_dir,
   // status
   output logic signed [`SMC_POS_W-1:0] motor_position,
   output smc_speed_t current_speed,
   output smc_status_s status,
   output logic move_refused
);

   smc_state_e state, next_state;
   smc_profile_s prof;
   logic [`SMC_NPIN-1:0] pin_raw, pin_lvl, pin_rise;
   logic halt_q, pause_q, cont_q, jcw_q, jccw_q;
   logic halt_rise, pause_rise, cont_rise, jcw_rise, jccw_rise, req_jog;
   logic moving, next_moving, can_start, imm_stop, lim_stop, dir_limit;
   logic jogging, dir, jog_level, tick, step_now;
   logic untrusted, cw_fault, ccw_fault, paused;
   logic signed [32:0] offs;
   logic [32:0] remaining, offs_mag;
   logic pos_dir, range_bad, refuse_pos, start_pos, start_jog, jog_blocked;
   smc_speed_t start_eff, cur_speed, goal, rate;
   logic [31:0] racc, racc_sum;
   logic [41:0] brake_need;
   logic [54:0] brake_have;
   logic brake;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: a level change counts once stages two and three agree
   assign pin_raw = {jog_stop_in, estop_in, limit_ccw_in, limit_cw_in};

   for (genvar i = 0; i < `SMC_NPIN; i++)
   begin : g_pin
      logic s1, s2, s3, lvl, lvl_q;
      always_ff @(posedge clock)
      begin
         if (reset)
         begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            lvl <= 1'b0;
            lvl_q <= 1'b0;
         end
         else
         begin
            s1 <= pin_raw[i];
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
            begin
               lvl <= s3;
            end
            lvl_q <= lvl;
         end
      end
      assign pin_lvl[i] = lvl;
      assign pin_rise[i] = lvl && !lvl_q;
   end

   // host bits are on our clock; only their previous value is kept
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         halt_q <= 1'b0;
         pause_q <= 1'b0;
         cont_q <= 1'b0;
         jcw_q <= 1'b0;
         jccw_q <= 1'b0;
      end
      else
      begin
         halt_q <= abrupt_halt_request;
         pause_q <= pause_request;
         cont_q <= continue_request;
         jcw_q <= jog_cw_cmd;
         jccw_q <= jog_ccw_cmd;
      end
   end

   assign halt_rise = abrupt_halt_request && !halt_q; // R5
   assign pause_rise = pause_request && !pause_q;
   assign cont_rise = continue_request && !cont_q;
   assign jcw_rise = jog_cw_cmd && !jcw_q;
   assign jccw_rise = jog_ccw_cmd && !jccw_q;
   assign req_jog = jcw_rise || jccw_rise;

   ////////////////////////////////////////////////////////////////////////////
   // stop causes and start checks
   assign start_eff = (start_speed < `SMC_SPEED_MIN) ? `SMC_SPEED_MIN : // R23
      (start_speed > `SMC_SPEED_MAX) ? `SMC_SPEED_MAX : start_speed;
   assign moving = (state == ST_RUN) || (state == ST_STOP) || (state == ST_HOLD);
   assign next_moving = (next_state == ST_RUN) || (next_state == ST_STOP) ||
      (next_state == ST_HOLD);
   assign can_start = (state == ST_IDLE) || (state == ST_PAUSED); // R12
   assign dir_limit = dir ? pin_lvl[`SMC_PIN_CW] : pin_lvl[`SMC_PIN_CCW];
   // any new limit edge stops; a held limit only stops travel into it
   assign lim_stop = moving && (pin_rise[`SMC_PIN_CW] || pin_rise[`SMC_PIN_CCW] ||
      dir_limit); // R7
   assign imm_stop = lim_stop || ((moving || state == ST_PAUSED) &&
      (halt_rise || pin_rise[`SMC_PIN_ESTOP])); // R5 R8
   assign jog_level = dir ? jog_cw_cmd : jog_ccw_cmd;

   // absolute offset is target minus position, relative is the target
   assign offs = (move_kind == SMC_KIND_ABS) ?
      ($signed({{9{move_target[`SMC_OFS_W-1]}}, move_target}) -
      $signed({motor_position[`SMC_POS_W-1], motor_position})) :
      $signed({{9{move_target[`SMC_OFS_W-1]}}, move_target}); // R9 R14
   assign pos_dir = offs > 0; // R14
   assign offs_mag = offs[32] ? 33'(-offs) : 33'(offs);
   assign range_bad = move_target == `SMC_OFS_BAD; // R9 R14
   assign refuse_pos = range_bad || ((move_kind == SMC_KIND_ABS) && untrusted) || // R4 R15
      ((offs != 0) && (pos_dir ? (pin_lvl[`SMC_PIN_CW] || cw_fault) :
      (pin_lvl[`SMC_PIN_CCW] || ccw_fault))); // R22
   // untrusted position blocks only absolute moves
   assign start_pos = can_start && !imm_stop && move_start && !refuse_pos &&
      (offs != 0); // R10
   // jog may leave an active limit in the other direction
   assign jog_blocked = jcw_rise ? (pin_lvl[`SMC_PIN_CW] || cw_fault) :
      (pin_lvl[`SMC_PIN_CCW] || ccw_fault); // R18 R22
   assign start_jog = can_start && !imm_stop && !move_start && req_jog && !jog_blocked;

   ////////////////////////////////////////////////////////////////////////////
   // move sequencing
   always_comb
   begin
      next_state = state;
      if (imm_stop)
      begin
         next_state = ST_IDLE; // R3
      end
      else
      begin
         case (state)
            ST_IDLE:
               if (start_pos || start_jog)
               begin
                  next_state = ST_RUN;
               end
            ST_PAUSED:
               if (start_pos || start_jog || cont_rise)
               begin
                  next_state = ST_RUN; // R12
               end
            ST_RUN:
               if (jogging)
               begin
                  if (!jog_level || pin_rise[`SMC_PIN_JSTOP] || pause_rise)
                  begin
                     next_state = ST_STOP; // R6 R17 R21
                  end
               end
               else if (step_now && remaining == 33'h0_0000_0001)
               begin
                  next_state = ST_IDLE;
               end
               else if (pause_rise)
               begin
                  next_state = ST_HOLD; // R11
               end
            ST_STOP, ST_HOLD:
               if (!jogging && step_now && remaining == 33'h0_0000_0001)
               begin
                  next_state = ST_IDLE;
               end
               else if (current_speed <= start_eff)
               begin
                  next_state = (state == ST_HOLD) ? ST_PAUSED : ST_IDLE; // R1 R11
               end
            default:
               next_state = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         state <= ST_IDLE;
      end
      else
      begin
         state <= next_state;
      end
   end

   // move parameters; continue reloads the profile but never the target
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         jogging <= 1'b0;
         dir <= 1'b0;
         remaining <= 33'h0_0000_0000;
         prof <= '0;
      end
      else if (start_pos)
      begin
         jogging <= 1'b0;
         dir <= pos_dir; // R9 R14
         remaining <= offs_mag;
         prof <= move_profile;
      end
      else if (start_jog)
      begin
         jogging <= 1'b1;
         dir <= jcw_rise; // R17
         remaining <= 33'h0_0000_0000;
         prof <= move_profile;
      end
      else if (state == ST_PAUSED && cont_rise && !imm_stop)
      begin
         prof <= move_profile; // R13
      end
      else
      begin
         if (step_now && !jogging)
         begin
            remaining <= remaining - 33'h0_0000_0001;
         end
         if (state == ST_RUN && jogging)
         begin
            prof.accel <= move_profile.accel; // R19
            prof.decel <= move_profile.decel;
            if (move_profile.speed >= start_eff)
            begin
               prof.speed <= move_profile.speed; // R20
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // speed ramp; braking distance avoids division by multiplying remaining by twice the decel
   assign brake_need = (current_speed * current_speed) - (start_eff * start_eff);
   assign brake_have = {remaining, 1'b0} * prof.decel;
   assign brake = !jogging && (current_speed > start_eff) &&
      ({13'h0000, brake_need} >= brake_have);
   assign goal = ((state == ST_STOP) || (state == ST_HOLD) || brake ||
      (prof.speed < start_eff)) ? start_eff : prof.speed; // R1
   assign rate = (current_speed < goal) ? prof.accel : prof.decel;
   assign racc_sum = racc + {11'h000, rate};

   always_ff @(posedge clock)
   begin
      if (reset || !next_moving)
      begin
         current_speed <= '0;
         racc <= 32'h0000_0000;
      end
      else if (!moving)
      begin
         current_speed <= start_eff; // R23
         racc <= 32'h0000_0000;
      end
      else if (current_speed == goal)
      begin
         racc <= 32'h0000_0000;
      end
      else if (racc_sum >= CLK_HZ)
      begin
         racc <= racc_sum - CLK_HZ;
         current_speed <= (current_speed < goal) ? current_speed + 1'b1 :
            current_speed - 1'b1; // R1 R19
      end
      else
      begin
         racc <= racc_sum;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // step output; an immediate stop vetoes the tick of the same cycle
   smc_step_rate #(.CLK_HZ(CLK_HZ)) u_rate (
      .clock(clock),
      .reset(reset),
      .enable(moving),
      .speed(current_speed),
      .tick(tick)
   );

   assign step_now = tick && moving && !imm_stop &&
      (jogging || remaining != 33'h0_0000_0000); // R3

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         step_pulse <= 1'b0;
      end
      else
      begin
         step_pulse <= step_now;
      end
   end
   assign step_dir = dir;

   // position count; preset and homing win over a step in the same cycle
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         motor_position <= `SMC_POS_RST;
      end
      else if (preset_strobe)
      begin
         motor_position <= preset_value;
      end
      else if (home_done)
      begin
         motor_position <= `SMC_HOME_POS;
      end
      else if (step_now)
      begin
         motor_position <= dir ? motor_position + 1'b1 : motor_position - 1'b1; // R24
      end
   end

   // trust flag: set by immediate stop wins over a clear
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         untrusted <= `SMC_UNTRUSTED_RST;
      end
      else if (imm_stop)
      begin
         untrusted <= 1'b1; // R3 R2
      end
      else if (preset_strobe || home_done)
      begin
         untrusted <= 1'b0; // R16
      end
   end

   // direction faults: only a limit hit in the travel direction latches
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         cw_fault <= 1'b0;
         ccw_fault <= 1'b0;
      end
      else
      begin
         if (lim_stop && dir && pin_lvl[`SMC_PIN_CW])
         begin
            cw_fault <= 1'b1; // R22
         end
         else if (clear_faults_cmd)
         begin
            cw_fault <= 1'b0;
         end
         if (lim_stop && !dir && pin_lvl[`SMC_PIN_CCW])
         begin
            ccw_fault <= 1'b1; // R22
         end
         else if (clear_faults_cmd)
         begin
            ccw_fault <= 1'b0;
         end
      end
   end

   // paused flag and refusal pulse
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         paused <= 1'b0;
         move_refused <= 1'b0;
      end
      else
      begin
         paused <= next_state == ST_PAUSED; // R11
         move_refused <= (move_start && !start_pos && !(can_start && offs == 0 &&
            !refuse_pos)) || (req_jog && !move_start && !start_jog);
      end
   end

   assign status = '{busy: moving, paused: paused, position_not_trusted: untrusted,
      cw_fault: cw_fault, ccw_fault: ccw_fault};

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   property p_imm_halt;
      imm_stop |=> !step_pulse && state == ST_IDLE && current_speed == '0;
   endproperty
   a_imm_halt: assert property (p_imm_halt) else $error("step after immediate stop"); // R3

   property p_imm_untrust;
      imm_stop |=> untrusted ##1 (untrusted || $past(preset_strobe || home_done));
   endproperty
   a_imm_untrust: assert property (p_imm_untrust) else $error("trust kept after halt"); // R3

   property p_abs_refused;
      can_start && move_start && move_kind == SMC_KIND_ABS && untrusted && !req_jog
         |=> state != ST_RUN && move_refused;
   endproperty
   a_abs_refused: assert property (p_abs_refused) else $error("absolute ran untrusted"); // R4

   property p_ctl_trust;
      (state == ST_STOP || state == ST_HOLD) && !imm_stop && !untrusted &&
         next_state != state |=> !untrusted;
   endproperty
   a_ctl_trust: assert property (p_ctl_trust) else $error("controlled stop lost trust"); // R2

   property p_step_count;
      step_pulse && !$past(preset_strobe) && !$past(home_done) |->
         motor_position == (step_dir ? $past(motor_position) + 1 : $past(motor_position) - 1);
   endproperty
   a_step_count: assert property (p_step_count) else $error("position miscounted"); // R24

   property p_pause_flag;
      $rose(paused) |-> $past(state) == ST_HOLD && current_speed == '0 && !moving;
   endproperty
   a_pause_flag: assert property (p_pause_flag) else $error("paused flag early"); // R11

   property p_jog_release;
      state == ST_RUN && jogging && !jog_level && !imm_stop |=> state == ST_STOP;
   endproperty
   a_jog_release: assert property (p_jog_release) else $error("jog release ignored"); // R21

   property p_jog_low;
      state == ST_RUN && jogging && move_profile.speed < start_eff |=> prof.speed ==
         $past(prof.speed);
   endproperty
   a_jog_low: assert property (p_jog_low) else $error("low jog speed taken"); // R20

   property p_fault_block;
      cw_fault && can_start && move_start && move_kind == SMC_KIND_REL && move_target > 0
         |=> state != ST_RUN;
   endproperty
   a_fault_block: assert property (p_fault_block) else $error("blocked direction ran"); // R22

   property p_start_speed;
      !moving && next_moving |=> current_speed == start_eff;
   endproperty
   a_start_speed: assert property (p_start_speed) else $error("start speed wrong"); // R23

   c_pause_resume: cover property (state == ST_PAUSED ##[1:1000] state == ST_RUN);
   c_jog_stop: cover property (state == ST_STOP && jogging ##1 state == ST_IDLE);
   c_limit_fault: cover property ($rose(cw_fault) || $rose(ccw_fault));
   c_pos_done: cover property (state == ST_RUN && !jogging ##1 state == ST_IDLE && !untrusted);

endmodule

// ===== smc_host_model.sv
`timescale 1ns/1ps
`include "smc_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// host side: command bits change only at falling edges
module smc_host_model
   import smc_pkg::*;
(
   // clock
   input wire logic clock,
   // move command
   output logic move_start,
   output smc_kind_e move_kind,
   output logic signed [`SMC_OFS_W-1:0] move_target,
   output smc_profile_s move_profile,
   // edge and pulse bits
   output logic abrupt_halt_request,
   output logic pause_request,
   output logic continue_request,
   output logic clear_faults_cmd,
   output logic preset_strobe,
   output logic home_done,
   output logic signed [`SMC_POS_W-1:0] preset_value,
   // jog levels
   output logic jog_cw_cmd,
   output logic jog_ccw_cmd
);
   logic [5:0] ev;

   // one vector so a single task raises any edge bit
   assign abrupt_halt_request = ev[0];
   assign pause_request = ev[1];
   assign continue_request = ev[2];
   assign clear_faults_cmd = ev[3];
   assign preset_strobe = ev[4];
   assign home_done = ev[5];

   // quiet bus at time zero
   initial
   begin
      ev = 6'h00;
      move_start = 1'b0;
      move_kind = SMC_KIND_REL;
      move_target = 24'h00_0000;
      move_profile = {21'h00_00C8, 21'h00_03E8, 21'h00_03E8};
      preset_value = 32'h0000_0000;
      jog_cw_cmd = 1'b0;
      jog_ccw_cmd = 1'b0;
   end

   // one-cycle start; fields go stale afterwards so nothing leans on them
   task automatic move(input smc_kind_e k, input logic signed [`SMC_OFS_W-1:0] t);
      @(negedge clock);
      move_start = 1'b1;
      move_kind = k;
      move_target = t;
      @(negedge clock);
      move_start = 1'b0;
      move_kind = smc_kind_e'(~k);
      move_target = ~t;
   endtask

   // raise one edge bit for n cycles, then drop it
   task automatic pulse(input int b, input int n);
      @(negedge clock);
      ev[b] = 1'b1;
      repeat (n) @(negedge clock);
      ev[b] = 1'b0;
   endtask
endmodule

// ===== tb.sv
`timescale 1ns/1ps
`include "smc_defs.svh"

`define CHK(what, exp, got) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) \
      begin \
         n_errors++; \
         $display("Error %s expected %0h seen %0h", what, exp, got); \
      end \
   end

module tb
   import smc_pkg::*;
;
   logic clock, reset, limit_cw_in, limit_ccw_in, estop_in, jog_stop_in;
   smc_speed_t start_speed, current_speed;
   logic move_start, pause_request, continue_request, abrupt_halt_request;
   logic clear_faults_cmd, jog_cw_cmd, jog_ccw_cmd, preset_strobe, home_done;
   smc_kind_e move_kind;
   logic signed [`SMC_OFS_W-1:0] move_target;
   logic signed [`SMC_POS_W-1:0] preset_value, motor_position, p;
   smc_profile_s move_profile;
   logic step_pulse, step_dir, move_refused;
   smc_status_s status;
   int n_errors = 0, cmp_count = 0, n_ref = 0, n_steps = 0, r0, s0;

   ////////////////////////////////////////////////////////////////////////////////
   // slow clock figure keeps step periods at three to ten cycles
   smc_move_ctrl #(.CLK_HZ(1000)) smc_move_ctrl_i (.clock, .reset, .move_start, .move_kind,
      .move_target, .move_profile, .pause_request, .continue_request, .abrupt_halt_request,
      .clear_faults_cmd, .jog_cw_cmd, .jog_ccw_cmd, .preset_strobe, .preset_value, .home_done,
      .start_speed, .limit_cw_in, .limit_ccw_in, .estop_in, .jog_stop_in, .step_pulse,
      .step_dir, .motor_position, .current_speed, .status, .move_refused);
   smc_host_model smc_host_model_i (.clock, .move_start, .move_kind, .move_target,
      .move_profile, .abrupt_halt_request, .pause_request, .continue_request,
      .clear_faults_cmd, .preset_strobe, .home_done, .preset_value, .jog_cw_cmd, .jog_ccw_cmd);

   // 5 ns period
   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // one-cycle output counts
   always @(posedge step_pulse) n_steps++;
   always @(posedge move_refused) n_ref++;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("errors %0d comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   function automatic logic done_now(input int sel);
      case (sel)
         0: return status.busy === 1'b0;
         1: return status.paused === 1'b1;
         default: return current_speed === 21'h00_012C;
      endcase
   endfunction

   // bounded wait; running out ends the run
   task automatic wait_on(input int sel, input int lim);
      int i;
      i = 0;
      while (i < lim && !done_now(sel))
      begin
         @(negedge clock);
         i++;
      end
      if (i == lim)
      begin
         n_errors++;
         $display("Error wait %0d expected done seen timeout", sel);
         report_and_stop();
      end
   endtask

   // start request that must be turned away
   task automatic refused(input smc_kind_e k, input logic signed [`SMC_OFS_W-1:0] t);
      r0 = n_ref;
      smc_host_model_i.move(k, t);
      repeat (2) @(negedge clock);
      `CHK("refused", 1, n_ref - r0);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // limit_ccw_in stays low: the cw side carries the limit cases
   initial
   begin
      reset = 1'b1;
      start_speed = 21'h00_0064;
      {limit_cw_in, limit_ccw_in, estop_in, jog_stop_in} = 4'h0;
      repeat (8) @(negedge clock);
      reset = 1'b0;
      `CHK("untrusted", 1'b1, status.position_not_trusted);
      refused(SMC_KIND_ABS, 24'sh00_0005);
      `CHK("busy", 1'b0, status.busy);
      s0 = n_steps;
      smc_host_model_i.move(SMC_KIND_REL, 24'sh00_0003);
      `CHK("dir", 1'b1, step_dir);
      wait_on(0, 200);
      `CHK("pos", 32'sd3, motor_position);
      `CHK("steps", 3, n_steps - s0);
      smc_host_model_i.move(SMC_KIND_REL, -24'sd2);
      `CHK("dir", 1'b0, step_dir);
      wait_on(0, 200);
      `CHK("pos", 32'sd1, motor_position);
      smc_host_model_i.preset_value = 32'sh0000_000A;
      smc_host_model_i.pulse(4, 1);
      `CHK("untrusted", 1'b0, status.position_not_trusted);
      smc_host_model_i.move(SMC_KIND_ABS, 24'sh00_0005);
      `CHK("dir", 1'b0, step_dir);
      wait_on(0, 500);
      smc_host_model_i.move(SMC_KIND_ABS, 24'sh00_0008);
      `CHK("dir", 1'b1, step_dir);
      wait_on(0, 500);
      `CHK("pos", 32'sd8, motor_position);
      refused(SMC_KIND_REL, 24'sh80_0000);
      smc_host_model_i.move(SMC_KIND_REL, 24'sh00_0190);
      repeat (300) @(negedge clock);
      smc_host_model_i.pulse(1, 2);
      wait_on(1, 1000);
      `CHK("speed", 21'h00_0000, current_speed);
      `CHK("held", 1'b1, motor_position < 32'sd408);
      smc_host_model_i.move_profile.speed = 21'h00_012C;
      smc_host_model_i.pulse(2, 2);
      wait_on(0, 20000);
      `CHK("pos", 32'sd408, motor_position);
      `CHK("untrusted", 1'b0, status.position_not_trusted);
      smc_host_model_i.move_profile.speed = 21'h00_00C8;
      smc_host_model_i.move(SMC_KIND_REL, 24'sh00_001E);
      repeat (50) @(negedge clock);
      jog_stop_in = 1'b1;
      repeat (10) @(negedge clock);
      jog_stop_in = 1'b0;
      wait_on(0, 1000);
      `CHK("pos", 32'sd438, motor_position);
      p = motor_position;
      smc_host_model_i.jog_cw_cmd = 1'b1;
      repeat (300) @(negedge clock);
      smc_host_model_i.move_profile.speed = 21'h00_0032;
      repeat (300) @(negedge clock);
      `CHK("speed", 21'h00_00C8, current_speed);
      smc_host_model_i.move_profile.speed = 21'h00_012C;
      wait_on(2, 500);
      `CHK("jog up", 1'b1, motor_position > p);
      smc_host_model_i.jog_cw_cmd = 1'b0;
      wait_on(0, 2000);
      `CHK("untrusted", 1'b0, status.position_not_trusted);
      smc_host_model_i.move_profile.speed = 21'h00_00C8;
      p = motor_position;
      smc_host_model_i.jog_ccw_cmd = 1'b1;
      repeat (300) @(negedge clock);
      jog_stop_in = 1'b1;
      wait_on(0, 2000);
      `CHK("jog down", 1'b1, motor_position < p);
      smc_host_model_i.jog_ccw_cmd = 1'b0;
      jog_stop_in = 1'b0;
      smc_host_model_i.move(SMC_KIND_REL, 24'sh00_03E8);
      repeat (200) @(negedge clock);
      smc_host_model_i.pulse(0, 2);
      wait_on(0, 1);
      `CHK("untrusted", 1'b1, status.position_not_trusted);
      refused(SMC_KIND_ABS, 24'sh00_0005);
      smc_host_model_i.pulse(5, 1);
      `CHK("untrusted", 1'b0, status.position_not_trusted);
      `CHK("pos", 32'sd0, motor_position);
      smc_host_model_i.move(SMC_KIND_REL, 24'sh00_03E8);
      repeat (200) @(negedge clock);
      estop_in = 1'b1;
      wait_on(0, 8);
      `CHK("untrusted", 1'b1, status.position_not_trusted);
      estop_in = 1'b0;
      repeat (10) @(negedge clock);
      smc_host_model_i.move(SMC_KIND_REL, 24'sh00_03E8);
      repeat (200) @(negedge clock);
      limit_cw_in = 1'b1;
      wait_on(0, 8);
      `CHK("cw fault", 1'b1, status.cw_fault);
      `CHK("ccw", 1'b0, status.ccw_fault);
      refused(SMC_KIND_REL, 24'sh00_0005);
      p = motor_position;
      smc_host_model_i.move(SMC_KIND_REL, -24'sd5);
      wait_on(0, 500);
      `CHK("pos", p - 32'sd5, motor_position);
      limit_cw_in = 1'b0;
      repeat (10) @(negedge clock);
      smc_host_model_i.pulse(3, 2);
      `CHK("cw fault", 1'b0, status.cw_fault);
      p = motor_position;
      smc_host_model_i.move(SMC_KIND_REL, 24'sh00_0002);
      wait_on(0, 500);
      `CHK("pos", p + 32'sd2, motor_position);
      report_and_stop();
   end
endmodule
